// ### verilog/ppp_port.sv
// Functional notes
// - ready_busy_n low during erase or programming, high when ready.
// - data bus driven by device only while output enable is low.
// - first byte select: 0 low byte, 1 high byte for loads and reads.
// - second byte select: 0 low byte, 1 second high byte.
// - pattern change within 100 ns of high level aborts entry.
// - load strobe action: 00 address, 01 data, 10 command, 11 none.
// - decode write commands: erase, fuses, lock bits, flash, eeprom.
// - decode read commands: signature, fuse/lock, flash, eeprom.
// - write or output-enable pulse executes latest loaded command.
// - command and address persist across operations.
// - erase clears flash, eeprom, then lock bits; fuses untouched.
// - keep-eeprom fuse programmed: erase leaves eeprom intact.
// - write pulse after erase command starts erase, busy goes low.
// - page latch pulse copies data bytes into page buffer word.
// - low address bits pick word, upper bits pick page.
// - flash write pulse programs buffered page, busy until done.
// - no-operation command ends page programming, clears write signals.
// - eeprom page filled by latches, written on pulse with select 0.
// - flash read drives low or high byte per select while enabled.
// - flash page 64 words, 128 pages.
// - eeprom page 4 bytes, 128 pages.
`timescale 1ns/1ps
`default_nettype none
module ppp_port
  import ppp_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = ERASE_CYC,
  parameter int unsigned WRITE_CYCLES = WRITE_CYC,
  parameter int          FIFO_DEPTH   = 2,
  // identity bytes: values arbitrary
  parameter logic [7:0]  SIG_BYTE0    = 8'h5a,
  parameter logic [7:0]  SIG_BYTE1    = 8'h3c,
  parameter logic [7:0]  SIG_BYTE2    = 8'h21,
  parameter logic [7:0]  CAL_BYTE     = 8'h80
) (
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       reset_n_in,
  // programming control pins
  input  wire logic       prog_voltage_in,
  input  wire logic       load_strobe_in,
  input  wire logic       strobe_action_bit0_in,
  input  wire logic       strobe_action_bit1_in,
  input  wire logic       byte_select_lo_hi_in,
  input  wire logic       byte_select_ext_in,
  input  wire logic       page_latch_strobe_in,
  input  wire logic       write_strobe_n_in,
  input  wire logic       output_enable_n_in,
  // data bus
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe_n_out,
  // status
  output logic            ready_busy_n_out,
  output logic            prog_mode_out
);
  localparam int FIFO_W  = 1 + FLASH_AW + 16;
  localparam int FIFO_PW = $clog2(FIFO_DEPTH);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic [PIN_W-1:0] pin_last;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
      pin_last <= PIN_IDLE;
    end else begin
      pin_meta <= {prog_voltage_in, load_strobe_in, strobe_action_bit1_in,
                   strobe_action_bit0_in, byte_select_lo_hi_in,
                   byte_select_ext_in, page_latch_strobe_in,
                   write_strobe_n_in, output_enable_n_in, data_in};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  logic       hv;
  logic [1:0] act;
  logic       bs1;
  logic       bs2;
  logic       oe_n;
  logic [7:0] din;
  logic [3:0] pattern;
  logic       hv_rise;
  logic       load_rise;
  logic       page_latch_strobe_rise;
  logic       wr_fall;
  assign hv         = pin_sync[16];
  assign act        = pin_sync[14:13];
  assign bs1        = pin_sync[12];
  assign bs2        = pin_sync[11];
  assign oe_n       = pin_sync[8];
  assign din        = pin_sync[7:0];
  assign pattern    = {pin_sync[10], pin_sync[14:12]};
  assign hv_rise    = hv & ~pin_last[16];
  assign load_rise  = pin_sync[15] & ~pin_last[15];
  assign page_latch_strobe_rise = pin_sync[10] & ~pin_last[10];
  assign wr_fall    = ~pin_sync[9] & pin_last[9];

  // ------------------------------------------------------------
  // programming mode entry
  // ------------------------------------------------------------
  logic       prog_mode;
  logic [2:0] toggles;
  logic       guarding;
  logic [7:0] guard_cnt;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prog_mode <= 1'b0;
      toggles   <= 3'h0;
      guarding  <= 1'b0;
      guard_cnt <= 8'h00;
    end else if (!hv) begin
      prog_mode <= 1'b0;
      guarding  <= 1'b0;
      if (load_rise && toggles != 3'h7)
        toggles <= toggles + 3'h1;
    end else if (hv_rise) begin
      toggles   <= 3'h0;
      guard_cnt <= 8'h00;
      guarding  <= (32'(toggles) >= STROBE_TOGGLES_MIN) && (pattern == 4'h0);
    end else if (guarding) begin
      // pins must hold still through the guard window
      if (pattern != 4'h0) begin
        guarding <= 1'b0;
      end else if (32'(guard_cnt) == ENTRY_GUARD_CYC - 1) begin
        guarding  <= 1'b0;
        prog_mode <= 1'b1;
      end else begin
        guard_cnt <= guard_cnt + 8'h01;
      end
    end
  end

  assign prog_mode_out = prog_mode;

  AST_ENTRY_ABORT: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    (guarding && hv && pattern != 4'h0) |=> !prog_mode [*2])
    else $error("entry completed despite pattern change");

  // ------------------------------------------------------------
  // command, address and data latches
  // ------------------------------------------------------------
  ppp_state_e state;
  logic [7:0] cmd;
  logic [7:0] addr_lo;
  logic [7:0] addr_hi;
  logic [7:0] data_lo;
  logic [7:0] data_hi;
  logic       write_armed;
  logic       idle;
  logic       load_ok;
  assign idle    = (state == ST_IDLE);
  assign load_ok = prog_mode && load_rise;

  // retained across operations, so one load serves many words
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      addr_lo <= 8'h00;
      addr_hi <= 8'h00;
      data_lo <= 8'hff;
      data_hi <= 8'hff;
    end else if (load_ok) begin
      if (act == ACT_ADDR && !bs1) addr_lo <= din;
      if (act == ACT_ADDR &&  bs1) addr_hi <= din;
      if (act == ACT_DATA && !bs1) data_lo <= din;
      if (act == ACT_DATA &&  bs1) data_hi <= din;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmd         <= CMD_NOP;
      write_armed <= 1'b0;
    end else if (load_ok && act == ACT_CMD && idle) begin
      cmd         <= din;
      write_armed <= (din == CMD_WR_FLASH) || (din == CMD_WR_EE);
    end
  end

  AST_CMD_FROZEN_BUSY: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    !idle |=> cmd == $past(cmd))
    else $error("command changed while busy");

  AST_ADDR_LO_LOAD: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    (load_ok && act == ACT_ADDR && !bs1) |=> addr_lo == $past(din))
    else $error("address low byte not loaded");

  AST_NOP_DISARMS: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    (load_ok && act == ACT_CMD && idle && din == CMD_NOP)
      |=> !write_armed && cmd == CMD_NOP)
    else $error("no-operation did not clear write signals");

  // ------------------------------------------------------------
  // page buffers
  // ------------------------------------------------------------
  localparam int FPW = 2 ** FLASH_PAGE_AW;
  localparam int EPW = 2 ** EE_PAGE_AW;
  logic [15:0]          fbuf  [FPW];
  logic [7:0]           ebuf  [EPW];
  logic [FPW-1:0]       fmask;
  logic [EPW-1:0]       emask;
  logic [FLASH_AW-1:0]  faddr;
  logic [EE_AW-1:0]     eaddr;
  logic                 latch_ok;
  logic                 commit_done;
  assign faddr    = FLASH_AW'({addr_hi, addr_lo});
  assign eaddr    = EE_AW'({addr_hi, addr_lo});
  assign latch_ok = prog_mode && page_latch_strobe_rise && idle;

  always_ff @(posedge clk_sys_in) begin
    if (latch_ok && cmd == CMD_WR_FLASH)
      fbuf[faddr[FLASH_PAGE_AW-1:0]] <= {data_hi, data_lo};
    if (latch_ok && cmd == CMD_WR_EE)
      ebuf[eaddr[EE_PAGE_AW-1:0]] <= data_lo;
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fmask <= '0;
      emask <= '0;
    end else if (commit_done || (load_ok && act == ACT_CMD && idle &&
                                 din == CMD_NOP)) begin
      fmask <= '0;
      emask <= '0;
    end else if (latch_ok && cmd == CMD_WR_FLASH) begin
      fmask[faddr[FLASH_PAGE_AW-1:0]] <= 1'b1;
    end else if (latch_ok && cmd == CMD_WR_EE) begin
      emask[eaddr[EE_PAGE_AW-1:0]] <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // operation sequencer
  // ------------------------------------------------------------
  logic [19:0]              busy_timer;
  logic [19:0]              op_limit;
  logic                     timer_done;
  logic [FLASH_AW-1:0]      sweep;
  logic                     sweep_done;
  logic [FLASH_PAGE_AW-1:0] cidx;
  logic                     commit_ee;
  logic                     cur_mask;
  logic                     clast;
  logic                     cstep;
  logic                     fifo_in_ready;
  logic                     fifo_out_valid;
  logic                     start_ok;
  logic                     start_op;
  assign timer_done  = busy_timer >= op_limit - 20'h1;
  assign cur_mask    = commit_ee ? emask[cidx[EE_PAGE_AW-1:0]] : fmask[cidx];
  assign clast       = commit_ee ? (32'(cidx) == EPW - 1)
                                 : (32'(cidx) == FPW - 1);
  assign cstep       = (state == ST_COMMIT) && (!cur_mask || fifo_in_ready);
  assign commit_done = cstep && clast;
  assign start_ok    = prog_mode && wr_fall && idle;
  assign start_op    = start_ok && (cmd == CMD_ERASE || cmd == CMD_WR_FUSE ||
    cmd == CMD_WR_LOCK || (cmd == CMD_WR_FLASH && write_armed) ||
    (cmd == CMD_WR_EE && write_armed && !bs1));

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state      <= ST_IDLE;
      busy_timer <= 20'h0;
      op_limit   <= 20'h1;
      commit_ee  <= 1'b0;
      cidx       <= '0;
    end else begin
      if (!idle)
        busy_timer <= busy_timer + 20'h1;
      case (state)
        ST_IDLE: begin
          busy_timer <= 20'h0;
          cidx       <= '0;
          commit_ee  <= (cmd == CMD_WR_EE);
          if (start_op) begin
            op_limit <= (cmd == CMD_ERASE) ? 20'(ERASE_CYCLES)
                                           : 20'(WRITE_CYCLES);
            if (cmd == CMD_ERASE)
              state <= ST_ERASE;
            else if (cmd == CMD_WR_FLASH || cmd == CMD_WR_EE)
              state <= ST_COMMIT;
            else
              state <= ST_HOLD;
          end
        end
        ST_ERASE: begin
          if (sweep_done && timer_done)
            state <= ST_IDLE;
        end
        ST_COMMIT: begin
          if (cstep)
            cidx <= cidx + 1'b1;
          if (commit_done)
            state <= ST_HOLD;
        end
        ST_HOLD: begin
          if (timer_done && !fifo_out_valid)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in)
      ready_busy_n_out <= 1'b1;
    else
      ready_busy_n_out <= (state == ST_IDLE) && !start_op;
  end

  AST_BUSY_ON_ERASE: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    (start_ok && cmd == CMD_ERASE) |=> !ready_busy_n_out && state == ST_ERASE)
    else $error("erase did not assert busy");

  AST_BUSY_MIN_TIME: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    (!idle ##1 idle) |-> $past(busy_timer) >= $past(op_limit) - 20'h1)
    else $error("busy ended before operation time");

  // ------------------------------------------------------------
  // erase sweep, fuses and lock bits
  // ------------------------------------------------------------
  logic [7:0] fuse_lo;
  logic [7:0] fuse_hi;
  logic [7:0] fuse_ext;
  logic [7:0] lock_bits;
  logic       keep_ee;
  logic       flash_erase_we;
  logic       ee_erase_we;
  // fuse acts at once, without re-entering programming mode
  assign keep_ee        = !fuse_hi[KEEP_EE_BIT];
  assign flash_erase_we = (state == ST_ERASE) && !sweep_done;
  assign ee_erase_we    = flash_erase_we && !keep_ee &&
                          (sweep < FLASH_AW'(2 ** EE_AW));

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sweep      <= '0;
      sweep_done <= 1'b0;
    end else if (state != ST_ERASE) begin
      sweep      <= '0;
      sweep_done <= 1'b0;
    end else if (!sweep_done) begin
      sweep      <= sweep + 1'b1;
      sweep_done <= (sweep == '1);
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fuse_lo   <= FUSE_LO_RST;
      fuse_hi   <= FUSE_HI_RST;
      fuse_ext  <= FUSE_EXT_RST;
      lock_bits <= LOCK_RST;
    end else if (state == ST_ERASE && sweep_done) begin
      lock_bits <= LOCK_RST;
    end else if (start_op && cmd == CMD_WR_LOCK) begin
      lock_bits <= lock_bits & data_lo;
    end else if (start_op && cmd == CMD_WR_FUSE) begin
      case ({bs2, bs1})
        2'b00:   fuse_lo  <= data_lo;
        2'b01:   fuse_hi  <= data_lo;
        2'b10:   fuse_ext <= data_lo;
        default: fuse_lo  <= fuse_lo;
      endcase
    end
  end

  AST_LOCK_AFTER_FLASH: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    ($past(state) == ST_ERASE && lock_bits != $past(lock_bits))
      |-> $past(sweep_done))
    else $error("lock bits cleared before flash erased");

  AST_EE_KEPT: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    ee_erase_we |-> state == ST_ERASE && fuse_hi[KEEP_EE_BIT])
    else $error("eeprom erased while keep fuse programmed");

  // ------------------------------------------------------------
  // word buffer between page commit and array
  // ------------------------------------------------------------
  logic [FIFO_W-1:0]  fifo_mem [FIFO_DEPTH];
  logic [FIFO_PW-1:0] wr_ptr;
  logic [FIFO_PW-1:0] rd_ptr;
  logic [FIFO_PW:0]   fifo_cnt;
  logic [FIFO_W-1:0]  fifo_head;
  logic [FIFO_W-1:0]  fifo_entry;
  logic               fifo_push;
  logic               fifo_pop;
  logic [3:0]         pace;
  logic               array_ready;
  logic [FLASH_AW-1:0] fword;
  logic [EE_AW-1:0]    eword;
  // page number from upper address bits, word from the walk index
  assign fword = {faddr[FLASH_AW-1:FLASH_PAGE_AW], cidx};
  assign eword = {eaddr[EE_AW-1:EE_PAGE_AW], cidx[EE_PAGE_AW-1:0]};
  assign fifo_entry = commit_ee ?
    {1'b1, FLASH_AW'(eword), 8'h00, ebuf[cidx[EE_PAGE_AW-1:0]]} :
    {1'b0, fword, fbuf[cidx]};
  assign fifo_in_ready  = (32'(fifo_cnt) < FIFO_DEPTH);
  assign fifo_out_valid = (fifo_cnt != '0);
  assign fifo_push      = (state == ST_COMMIT) && cur_mask && fifo_in_ready;
  // array accepts one word per pace period, so the commit walk stalls
  assign array_ready    = (32'(pace) == WORD_PACE_CYC - 1);
  assign fifo_pop       = fifo_out_valid && array_ready;
  assign fifo_head      = fifo_mem[rd_ptr];

  always_ff @(posedge clk_sys_in) begin
    if (fifo_push)
      fifo_mem[wr_ptr] <= fifo_entry;
  end

  // depth must be a power of two for the pointer wrap
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      fifo_cnt <= '0;
      pace     <= 4'h0;
    end else begin
      pace <= array_ready ? 4'h0 : pace + 4'h1;
      if (fifo_push)
        wr_ptr <= wr_ptr + 1'b1;
      if (fifo_pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (fifo_push && !fifo_pop)
        fifo_cnt <= fifo_cnt + 1'b1;
      else if (fifo_pop && !fifo_push)
        fifo_cnt <= fifo_cnt - 1'b1;
    end
  end

  // ------------------------------------------------------------
  // memory arrays
  // ------------------------------------------------------------
  logic [15:0] flash_mem [2 ** FLASH_AW];
  logic [7:0]  ee_mem    [2 ** EE_AW];

  always_ff @(posedge clk_sys_in) begin
    if (flash_erase_we)
      flash_mem[sweep] <= ERASED_WORD;
    else if (fifo_pop && !fifo_head[FIFO_W-1])
      flash_mem[fifo_head[FIFO_W-2:16]] <= fifo_head[15:0];
  end

  always_ff @(posedge clk_sys_in) begin
    if (ee_erase_we)
      ee_mem[sweep[EE_AW-1:0]] <= ERASED_WORD[7:0];
    else if (fifo_pop && fifo_head[FIFO_W-1])
      ee_mem[fifo_head[EE_AW+15:16]] <= fifo_head[7:0];
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  logic [15:0] rd_word;
  logic [7:0]  next_data;
  assign rd_word = flash_mem[faddr];

  always_comb begin
    next_data = 8'h00;
    case (cmd)
      CMD_RD_FLASH:
        next_data = bs1 ? rd_word[15:8] : rd_word[7:0];
      CMD_RD_EE:    next_data = ee_mem[eaddr];
      CMD_RD_FUSE: begin
        case ({bs2, bs1})
          2'b00:   next_data = fuse_lo;
          2'b11:   next_data = fuse_hi;
          2'b10:   next_data = fuse_ext;
          default: next_data = lock_bits;
        endcase
      end
      CMD_RD_SIG: begin
        if (bs1)
          next_data = CAL_BYTE;
        else if (addr_lo[1:0] == 2'b00)
          next_data = SIG_BYTE0;
        else if (addr_lo[1:0] == 2'b01)
          next_data = SIG_BYTE1;
        else
          next_data = SIG_BYTE2;
      end
      default: next_data = 8'hff;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data_out      <= 8'h00;
      data_oe_n_out <= 1'b1;
    end else begin
      data_oe_n_out <= !(prog_mode && !oe_n);
      if (!oe_n)
        data_out <= next_data;
    end
  end

  AST_BUS_RELEASE: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    (oe_n || !prog_mode) |=> data_oe_n_out)
    else $error("bus driven without output enable");

  AST_FLASH_READ_BYTE: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    (cmd == CMD_RD_FLASH && !oe_n && prog_mode)
      |=> data_out == ($past(bs1) ? $past(rd_word[15:8])
                                  : $past(rd_word[7:0])))
    else $error("flash read byte mismatch");
endmodule : ppp_port
`default_nettype wire

// ### verilog/ppp_pkg.sv
`default_nettype none
package ppp_pkg;
  // command bytes
  localparam logic [7:0] CMD_NOP      = 8'h00;
  localparam logic [7:0] CMD_ERASE    = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE    = 8'h11;
  localparam logic [7:0] CMD_RD_SIG   = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE    = 8'h03;
  // load strobe actions {bit1, bit0}
  localparam logic [1:0] ACT_ADDR = 2'b00;
  localparam logic [1:0] ACT_DATA = 2'b01;
  localparam logic [1:0] ACT_CMD  = 2'b10;
  // geometry
  localparam int FLASH_AW       = 13;
  localparam int FLASH_PAGE_AW  = 6;
  localparam int EE_AW          = 9;
  localparam int EE_PAGE_AW     = 2;
  // reset values, erased values, fuse positions
  localparam logic [7:0]  FUSE_LO_RST  = 8'h62;
  localparam logic [7:0]  FUSE_HI_RST  = 8'h99;
  localparam logic [7:0]  FUSE_EXT_RST = 8'hff;
  localparam logic [7:0]  LOCK_RST     = 8'hff;
  localparam logic [15:0] ERASED_WORD  = 16'hffff;
  localparam int          KEEP_EE_BIT  = 3;
  // pin sampling vector: hv, load, act[1:0], bs1, bs2, page_latch_strobe, wr_n, oe_n, data
  localparam int          PIN_W        = 17;
  localparam logic [16:0] PIN_IDLE     = 17'h00300;
  // timing
  localparam int  CLK_PERIOD_NS      = 10;
  localparam int  STROBE_TOGGLES_MIN = 6;
  localparam int  ENTRY_GUARD_NS     = 100;
  localparam int  ENTRY_GUARD_CYC    =
    (ENTRY_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam real ERASE_TIME_MS      = 7.5;
  localparam real WRITE_TIME_MS      = 3.7;
  localparam int  ERASE_CYC =
    int'($ceil(ERASE_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int  WRITE_CYC =
    int'($ceil(WRITE_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int  WORD_PACE_CYC      = 2;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ERASE  = 2'b01,
    ST_COMMIT = 2'b10,
    ST_HOLD   = 2'b11
  } ppp_state_e;
endpackage : ppp_pkg
`default_nettype wire

// ### bench/ppp_prog.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_prog (
  // clock and bus level
  input  wire logic       clk_in,
  input  wire logic [7:0] bus_in,
  // pins toward the port
  output var  logic       hv_out,
  output var  logic       ld_out,
  output var  logic [1:0] act_out,
  output var  logic       bs1_out,
  output var  logic       bs2_out,
  output var  logic       pgl_out,
  output var  logic       wr_n_out,
  output var  logic       oe_n_out,
  output var  logic [7:0] dat_out
);
  initial begin
    {hv_out, ld_out, act_out, bs1_out, bs2_out, pgl_out} = '0;
    {wr_n_out, oe_n_out} = 2'b11;
    dat_out = 8'h00;
  end
  // four cycles a phase: the port syncs every pin through two flops
  task automatic step();
    repeat (4) @(posedge clk_in);
  endtask : step
  // spoil moves the entry pattern inside the guard window, entry must fail
  task automatic enter(input logic spoil);
    repeat (6) begin
      ld_out <= 1'b1;
      step();
      ld_out <= 1'b0;
      step();
    end
    hv_out <= 1'b1;
    if (spoil) begin
      step();
      pgl_out <= 1'b1;
      step();
      pgl_out <= 1'b0;
      hv_out <= 1'b0;
      step();
    end else begin
      repeat (5000) @(posedge clk_in);
    end
  endtask : enter
  task automatic load(input logic [1:0] a, input logic b, input logic [7:0] d);
    act_out <= a;
    bs1_out <= b;
    dat_out <= d;
    step();
    ld_out <= 1'b1;
    step();
    ld_out <= 1'b0;
    step();
  endtask : load
  task automatic latch();
    pgl_out <= 1'b1;
    step();
    pgl_out <= 1'b0;
    step();
  endtask : latch
  task automatic wr_pulse();
    wr_n_out <= 1'b0;
    step();
    wr_n_out <= 1'b1;
    step();
  endtask : wr_pulse
  task automatic read(input logic b2, input logic b1, output logic [7:0] d);
    bs2_out <= b2;
    bs1_out <= b1;
    oe_n_out <= 1'b0;
    step();
    step();
    d = bus_in;
    oe_n_out <= 1'b1;
    step();
  endtask : read
endmodule : ppp_prog
`default_nettype wire

// ### bench/ppp_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_port_test;
  import ppp_pkg::*;
  logic       clk, reset_n, hv, ld, bs1, bs2, pgl, wr_n, oe_n, rdy, pm, doe_n;
  logic [1:0] act;
  logic [7:0] pd, dd, bus, rd;
  int         errors = 0;
  int         checked = 0;
  int         cyc = 0;
  initial clk = 1'b0;
  initial reset_n = 1'b0;
  always #5 clk = ~clk;
  // a released bus shows the programmer's last byte, inverted while output enable is low
  assign bus = !doe_n ? dd : (oe_n ? pd : ~pd);
  ppp_port #(.ERASE_CYCLES(20), .WRITE_CYCLES(10), .SIG_BYTE1(8'h6b))
    i_ppp_port (
    .clk_sys_in(clk), .reset_n_in(reset_n), .prog_voltage_in(hv),
    .load_strobe_in(ld), .strobe_action_bit0_in(act[0]),
    .strobe_action_bit1_in(act[1]), .byte_select_lo_hi_in(bs1),
    .byte_select_ext_in(bs2), .page_latch_strobe_in(pgl),
    .write_strobe_n_in(wr_n), .output_enable_n_in(oe_n), .data_in(bus),
    .data_out(dd), .data_oe_n_out(doe_n), .ready_busy_n_out(rdy),
    .prog_mode_out(pm));
  ppp_prog i_ppp_prog (.clk_in(clk), .bus_in(bus), .hv_out(hv),
    .ld_out(ld), .act_out(act), .bs1_out(bs1), .bs2_out(bs2),
    .pgl_out(pgl), .wr_n_out(wr_n), .oe_n_out(oe_n), .dat_out(pd));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      close_out();
    end
  end
  task automatic wait_ready();
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    check({7'h0, rdy}, 8'h01);
  endtask : wait_ready
  task automatic t_erase();
    i_ppp_prog.load(ACT_CMD, 1'b0, CMD_ERASE);
    i_ppp_prog.wr_pulse();
    check({7'h0, rdy}, 8'h00);
    wait_ready();
  endtask : t_erase
  task automatic t_flash();
    i_ppp_prog.load(ACT_CMD, 1'b0, CMD_WR_FLASH);
    i_ppp_prog.load(ACT_ADDR, 1'b0, 8'h45);
    i_ppp_prog.load(ACT_DATA, 1'b0, 8'h34);
    i_ppp_prog.load(ACT_DATA, 1'b1, 8'h12);
    i_ppp_prog.latch();
    i_ppp_prog.load(ACT_ADDR, 1'b1, 8'h00);
    i_ppp_prog.wr_pulse();
    check({7'h0, rdy}, 8'h00);
    wait_ready();
    i_ppp_prog.load(ACT_CMD, 1'b0, CMD_NOP);
  endtask : t_flash
  task automatic t_read();
    i_ppp_prog.load(ACT_CMD, 1'b0, CMD_RD_FLASH);
    i_ppp_prog.load(ACT_ADDR, 1'b0, 8'h45);
    i_ppp_prog.read(1'b0, 1'b0, rd);
    check(rd, 8'h34);
    i_ppp_prog.read(1'b0, 1'b1, rd);
    check(rd, 8'h12);
    check({7'h0, doe_n}, 8'h01);
    i_ppp_prog.load(ACT_ADDR, 1'b0, 8'h46);
    i_ppp_prog.read(1'b0, 1'b0, rd);
    check(rd, 8'hff);
    i_ppp_prog.load(ACT_CMD, 1'b0, CMD_RD_FUSE);
    i_ppp_prog.read(1'b0, 1'b0, rd);
    check(rd, FUSE_LO_RST);
    i_ppp_prog.read(1'b0, 1'b1, rd);
    check(rd, 8'hff);
  endtask : t_read
  task automatic t_ee();
    i_ppp_prog.load(ACT_CMD, 1'b0, CMD_WR_EE);
    i_ppp_prog.load(ACT_ADDR, 1'b0, 8'h02);
    i_ppp_prog.load(ACT_DATA, 1'b0, 8'ha5);
    i_ppp_prog.load(2'b11, 1'b0, 8'h77);
    i_ppp_prog.latch();
    i_ppp_prog.wr_pulse();
    check({7'h0, rdy}, 8'h00);
    wait_ready();
    i_ppp_prog.load(ACT_CMD, 1'b0, CMD_RD_EE);
    i_ppp_prog.read(1'b0, 1'b0, rd);
    check(rd, 8'ha5);
  endtask : t_ee
  // keep-eeprom fuse and lock bits programmed, then a second erase
  task automatic t_fuse();
    i_ppp_prog.load(ACT_CMD, 1'b0, CMD_WR_FUSE);
    i_ppp_prog.load(ACT_DATA, 1'b0, 8'h91);
    i_ppp_prog.load(2'b11, 1'b1, 8'h00);
    i_ppp_prog.wr_pulse();
    check({7'h0, rdy}, 8'h00);
    wait_ready();
    i_ppp_prog.load(ACT_CMD, 1'b0, CMD_WR_LOCK);
    i_ppp_prog.load(ACT_DATA, 1'b0, 8'hfc);
    i_ppp_prog.wr_pulse();
    wait_ready();
    i_ppp_prog.load(ACT_CMD, 1'b0, CMD_RD_FUSE);
    i_ppp_prog.read(1'b1, 1'b1, rd);
    check(rd, 8'h91);
    i_ppp_prog.read(1'b0, 1'b1, rd);
    check(rd, 8'hfc);
    t_erase();
    i_ppp_prog.load(ACT_CMD, 1'b0, CMD_RD_FUSE);
    i_ppp_prog.read(1'b1, 1'b1, rd);
    check(rd, 8'h91);
    i_ppp_prog.read(1'b0, 1'b1, rd);
    check(rd, 8'hff);
    i_ppp_prog.load(ACT_CMD, 1'b0, CMD_RD_EE);
    i_ppp_prog.read(1'b0, 1'b0, rd);
    check(rd, 8'ha5);
    i_ppp_prog.load(ACT_CMD, 1'b0, CMD_RD_SIG);
    i_ppp_prog.load(ACT_ADDR, 1'b0, 8'h01);
    i_ppp_prog.read(1'b0, 1'b0, rd);
    check(rd, 8'h6b);
  endtask : t_fuse
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    i_ppp_prog.enter(1'b1);
    check({7'h0, pm}, 8'h00);
    i_ppp_prog.enter(1'b0);
    check({7'h0, pm}, 8'h01);
    t_erase();
    t_flash();
    t_read();
    t_ee();
    t_fuse();
    close_out();
  end
endmodule : ppp_port_test
`default_nettype wire
